// File: sfpi_defines.svh
// constants of the serial flash pin front end
`ifndef SFPI_DEFINES_SVH
`define SFPI_DEFINES_SVH
`define SFPI_CMD_FOUR_LANE_ON 8'h38
`define SFPI_CMD_FOUR_LANE_OFF 8'hFF
`define SFPI_CMD_SOFT_RESET 8'h99
`define SFPI_LOCK_HARDWARE 2'h1
`define SFPI_SECTORS 8'h80
`define SFPI_IDLE_BYTE 8'hFF
`define SFPI_OE_SINGLE 4'h2
`define SFPI_OE_DUAL 4'h3
`define SFPI_OE_QUAD 4'hF
`endif

// File: sfpi_host_model.sv
// host controller model driving the serial pins of the flash front end
`timescale 1ns/100ps
`default_nettype none
module sfpi_host_model (
    input wire logic clk,
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] lanes
);
    logic [3:0] h_oe;
    logic [3:0] h_val;
    logic [3:0] idle_v;
    logic flt;
    // select starts low so the first frame has no falling select edge
    initial begin
        sclk = 1'b0; // clock idles low at select edges
        cs_n = 1'b0;
        h_oe = 4'hD;
        h_val = 4'hF;
        idle_v = 4'hF;
        flt = 1'b0;
    end
    // released lanes wander so a stale level never passes for data
    always @(posedge clk) flt <= ~flt;
    assign lanes = (dev_oe & dev_out) | (~dev_oe & h_oe & h_val) | (~dev_oe & ~h_oe & {4{flt}});
    task automatic cs(input logic v);
        @(posedge clk);
        cs_n <= v; // falling select edge opens each frame
        h_oe <= 4'hD;
        repeat (6) @(posedge clk);
    endtask
    task automatic pin(input logic [3:0] v);
        @(posedge clk);
        idle_v <= v;
        h_val <= v;
        h_oe <= 4'hD;
        repeat (6) @(posedge clk);
    endtask
    // host sets lanes while clock low and samples the device on the rise
    task automatic xfer(input logic [7:0] tx, input int w, input logic rd, input int nb,
        output logic [7:0] rx);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        rx = 8'h00;
        @(posedge clk);
        h_oe <= rd ? (~m & 4'hC) : (m | 4'hC);
        for (int i = 0; i < nb / w; i++) begin
            @(posedge clk);
            h_val <= (4'(tx >> (8 - w)) & m) | (idle_v & ~m);
            tx = tx << w;
            repeat (4) @(posedge clk);
            // single lane reads come back on lane 1, not on the input lane
            rx = (rx << w) | ((w == 1) ? 8'(lanes[1]) : 8'(lanes & m));
            sclk <= 1'b1;
            repeat (5) @(posedge clk);
            sclk <= 1'b0;
        end
    endtask
endmodule // sfpi_host_model
`default_nettype wire

// File: sfpi_pin_front.sv
// pin front end: sampling, lane steering, pause, write guard, rx buffer
`timescale 1ns/100ps
`default_nettype none
`include "sfpi_defines.svh"
module sfpi_pin_front (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_lane_in,
    output logic [3:0] io_lane_out,
    output logic [3:0] io_lane_oe,
    input wire logic four_lane_enable_bit,
    input wire logic [1:0] status_lock_bits,
    input wire sfpi_pkg::sfpi_guard_t guard_bits,
    input wire sfpi_pkg::sfpi_phase_t phase,
    input wire logic core_busy,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output sfpi_pkg::sfpi_rx_t rx_word,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_full,
    output logic rx_overrun,
    output logic selected,
    output logic paused,
    output logic four_lane_command_mode,
    output logic standby,
    output logic sr_write_refused,
    output logic protect_any,
    output logic [6:0] protect_lo,
    output logic [6:0] protect_hi
);
    import sfpi_pkg::*;

    function automatic logic [14:0] guard_region(input sfpi_guard_t g);
        logic [7:0] size;
        logic [7:0] lo;
        logic [7:0] hi;
        logic any;
        size = 8'h00;
        if (g.bp != 3'h0) begin
            if (g.sec)
                size = (g.bp > 3'h4) ? 8'h08 : 8'(8'h01 << (g.bp - 3'h1));
            else
                size = (g.bp > 3'h4) ? `SFPI_SECTORS : 8'(8'h10 << (g.bp - 3'h1));
        end
        any = (size != 8'h00);
        lo = g.tb ? 8'h00 : 8'(`SFPI_SECTORS - size);
        hi = g.tb ? 8'(size - 8'h01) : 8'(`SFPI_SECTORS - 8'h01);
        if (g.cmp) begin
            any = (size != `SFPI_SECTORS);
            lo = (g.tb && size != 8'h00) ? size : 8'h00;
            hi = (g.tb || size == 8'h00) ? 8'(`SFPI_SECTORS - 8'h01)
                                         : 8'(`SFPI_SECTORS - size - 8'h01);
        end
        return {any, lo[6:0], hi[6:0]};
    endfunction

    function automatic logic [3:0] lane_step(input sfpi_width_t w);
        return (w == sfpi_w4) ? 4'h4 : (w == sfpi_w2) ? 4'h2 : 4'h1;
    endfunction

    // two-stage synchronisers; the first stage is never read, and sclk has a third delay stage for edge detection
    logic sclk_m_reg, sclk_s_reg, sclk_d_reg;
    logic cs_m_reg, cs_s_reg;
    logic [3:0] io_m_reg, io_s_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_m_reg <= 1'b0;
            sclk_s_reg <= 1'b0;
            sclk_d_reg <= 1'b0;
            // reset level must not count as a seen-high select, or arming is false
            cs_m_reg <= 1'b0;
            cs_s_reg <= 1'b0;
            io_m_reg <= 4'hF;
            io_s_reg <= 4'hF;
        end else begin
            sclk_m_reg <= sclk;
            sclk_s_reg <= sclk_m_reg;
            sclk_d_reg <= sclk_s_reg;
            cs_m_reg <= cs_n;
            cs_s_reg <= cs_m_reg;
            io_m_reg <= io_lane_in;
            io_s_reg <= io_m_reg;
        end
    end

    logic armed_reg, qpi_reg, pause_reg, first_reg;
    logic [2:0] rcnt_reg, tcnt_reg;
    logic [7:0] rsh_reg, tsh_reg;

    // select edge only counts once select has been seen high
    wire logic sel_now = ~cs_s_reg & armed_reg;
    // clock level at select edges is irrelevant: only edges inside a frame count
    wire logic active = sel_now & ~pause_reg;
    wire logic rise = active & sclk_s_reg & ~sclk_d_reg;
    wire logic fall = active & ~sclk_s_reg & sclk_d_reg;
    wire logic qe = four_lane_enable_bit;
    wire logic pause_req = sel_now & ~qe & ~io_s_reg[3];
    wire sfpi_width_t req_width = (phase.width == sfpi_w4 && !qe) ? sfpi_w1 : phase.width;
    wire sfpi_width_t width = qpi_reg ? sfpi_w4 : (first_reg ? sfpi_w1 : req_width);
    wire logic drive = ~first_reg & phase.drive;
    wire logic [3:0] step = lane_step(width);
    wire logic [7:0] rsh_next = (width == sfpi_w4) ? {rsh_reg[3:0], io_s_reg} :
                                (width == sfpi_w2) ? {rsh_reg[5:0], io_s_reg[1:0]} :
                                {rsh_reg[6:0], io_s_reg[0]};
    wire logic [2:0] rcnt_next = 3'(rcnt_reg + step[2:0]);
    wire logic byte_done = rise & ~drive & (rcnt_next == 3'h0);
    wire logic [7:0] tword = (tcnt_reg == 3'h0) ? (tx_valid ? tx_data : `SFPI_IDLE_BYTE) : tsh_reg;
    wire logic [3:0] out_next = (width == sfpi_w4) ? tword[7:4] :
                                (width == sfpi_w2) ? {2'h0, tword[7:6]} :
                                {2'h0, tword[7], 1'b0};
    wire logic [3:0] oe_next = (!active || !drive) ? 4'h0 :
                               (width == sfpi_w4) ? `SFPI_OE_QUAD :
                               (width == sfpi_w2) ? `SFPI_OE_DUAL : `SFPI_OE_SINGLE;
    wire logic [14:0] region = guard_region(guard_bits);
    wire logic guard_on = ~qe & ~io_s_reg[2] & (status_lock_bits == `SFPI_LOCK_HARDWARE);

    // frame, mode and pause state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            armed_reg <= 1'b0;
            qpi_reg <= 1'b0;
            pause_reg <= 1'b0;
            first_reg <= 1'b1;
        end else begin
            if (cs_s_reg)
                armed_reg <= 1'b1;
            // clock low: follow pin now; clock high: wait for the next fall
            if ((!pause_req && !sel_now) || qe)
                pause_reg <= 1'b0;
            else if (!sclk_s_reg)
                pause_reg <= pause_req;
            if (!sel_now)
                first_reg <= 1'b1;
            else if (byte_done)
                first_reg <= 1'b0;
            if (byte_done && first_reg) begin
                if (rsh_next == `SFPI_CMD_FOUR_LANE_ON && qe)
                    qpi_reg <= 1'b1;
                else if (rsh_next == `SFPI_CMD_FOUR_LANE_OFF || rsh_next == `SFPI_CMD_SOFT_RESET)
                    qpi_reg <= 1'b0;
            end
        end
    end

    // shifters hold while paused, so release continues mid-byte
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rcnt_reg <= 3'h0;
            tcnt_reg <= 3'h0;
            rsh_reg <= 8'h00;
            tsh_reg <= 8'h00;
            io_lane_out <= 4'h0;
            io_lane_oe <= 4'h0;
            tx_ready <= 1'b0;
        end else begin
            io_lane_oe <= oe_next;
            tx_ready <= fall & drive & (tcnt_reg == 3'h0) & tx_valid;
            if (!sel_now) begin
                rcnt_reg <= 3'h0;
                tcnt_reg <= 3'h0;
            end else if (rise && !drive) begin
                rsh_reg <= rsh_next;
                rcnt_reg <= rcnt_next;
            end else if (fall && drive) begin
                io_lane_out <= out_next;
                tsh_reg <= 8'(tword << step);
                tcnt_reg <= 3'(tcnt_reg + step[2:0]);
            end
        end
    end

    // two-entry rx buffer: output head plus one spare
    sfpi_rx_t spare_reg;
    logic spare_v_reg;
    wire sfpi_rx_t push_word = '{data: rsh_next, first: first_reg};
    wire logic pop = rx_valid & rx_ready;
    wire logic take_head = pop | ~rx_valid;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_word <= '0;
            rx_valid <= 1'b0;
            spare_reg <= '0;
            spare_v_reg <= 1'b0;
            rx_overrun <= 1'b0;
        end else begin
            rx_overrun <= byte_done & rx_valid & spare_v_reg & ~pop;
            if (take_head && spare_v_reg) begin
                rx_word <= spare_reg;
                rx_valid <= 1'b1;
                spare_reg <= push_word;
                spare_v_reg <= byte_done;
            end else if (take_head) begin
                rx_word <= push_word;
                rx_valid <= byte_done;
            end else if (byte_done && !spare_v_reg) begin
                spare_reg <= push_word;
                spare_v_reg <= 1'b1;
            end
        end
    end

    // status outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            selected <= 1'b0;
            paused <= 1'b0;
            four_lane_command_mode <= 1'b0;
            standby <= 1'b0;
            sr_write_refused <= 1'b0;
            protect_any <= 1'b0;
            protect_lo <= 7'h00;
            protect_hi <= 7'h00;
            rx_full <= 1'b0;
        end else begin
            selected <= sel_now;
            paused <= pause_reg;
            four_lane_command_mode <= qpi_reg;
            // deselect never aborts a running internal cycle
            standby <= cs_s_reg & ~core_busy;
            sr_write_refused <= guard_on;
            protect_any <= region[14] & guard_on;
            protect_lo <= region[13:7];
            protect_hi <= region[6:0];
            rx_full <= spare_v_reg;
        end
    end

    a_oe_deselect: assert property (@(posedge clk) disable iff (reset)
        cs_s_reg |=> io_lane_oe == 4'h0) else $error("lanes driven while deselected");
    a_oe_paused: assert property (@(posedge clk) disable iff (reset)
        pause_reg |=> io_lane_oe == 4'h0) else $error("lanes driven while paused");
    a_oe_input_phase: assert property (@(posedge clk) disable iff (reset)
        !drive |=> io_lane_oe == 4'h0) else $error("lanes driven in input phase");
    a_quad_needs_qe: assert property (@(posedge clk) disable iff (reset)
        (io_lane_oe == `SFPI_OE_QUAD) |-> $past(qe)) else $error("quad lanes without enable");
    a_pause_qe_off: assert property (@(posedge clk) disable iff (reset)
        qe [*2] |-> !pause_reg) else $error("pause active with four-lane enable");
    a_guard_qe_off: assert property (@(posedge clk) disable iff (reset)
        $past(qe) |-> !sr_write_refused) else $error("guard active with four-lane enable");
    a_unarmed_idle: assert property (@(posedge clk) disable iff (reset)
        !armed_reg |-> !byte_done && !first_reg == 1'b0) else $error("byte taken before arming");
    a_pause_holds: assert property (@(posedge clk) disable iff (reset)
        pause_reg ##1 pause_reg |-> $stable(rsh_reg) && $stable(rcnt_reg)) else $error("shift moved in pause");
    a_mode_enter: assert property (@(posedge clk) disable iff (reset)
        byte_done && first_reg && qe && rsh_next == `SFPI_CMD_FOUR_LANE_ON |=> ##1 four_lane_command_mode)
        else $error("four-lane mode not entered");
    a_qpi_two_clocks: assert property (@(posedge clk) disable iff (reset)
        qpi_reg && rise && !drive |-> rcnt_next == 3'(rcnt_reg + 3'h4)) else $error("instruction width wrong");

    c_qpi_entry: cover property (@(posedge clk) disable iff (reset) $rose(qpi_reg));
    c_pause: cover property (@(posedge clk) disable iff (reset) $fell(pause_reg) && sel_now);
    c_quad_read: cover property (@(posedge clk) disable iff (reset) io_lane_oe == `SFPI_OE_QUAD);
    c_overrun: cover property (@(posedge clk) disable iff (reset) rx_overrun);
endmodule // sfpi_pin_front
`default_nettype wire

// File: sfpi_pin_front_tb.sv
// self-checking bench of the serial flash pin front end
`timescale 1ns/100ps
`default_nettype none
`include "sfpi_defines.svh"
module sfpi_pin_front_tb;
    import sfpi_pkg::*;
    logic clk = 1'b0;
    logic reset;
    logic four_lane_enable_bit;
    logic [1:0] status_lock_bits;
    sfpi_guard_t guard_bits;
    sfpi_phase_t phase;
    logic core_busy;
    logic [7:0] tx_data;
    logic tx_valid;
    logic rx_ready;
    logic tx_ready;
    int n_txr = 0;
    int txr0;
    logic sclk, cs_n, rx_valid, rx_full, rx_overrun, selected, paused, standby;
    logic four_lane_command_mode, sr_write_refused, protect_any;
    logic [3:0] lanes, io_lane_out, io_lane_oe;
    logic [6:0] protect_lo, protect_hi;
    sfpi_rx_t rx_word;
    logic [7:0] rd;
    logic ovr = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;
    sfpi_width_t wt[4] = '{sfpi_w1, sfpi_w2, sfpi_w4, sfpi_w4};
    int wl[4] = '{1, 2, 1, 4};
    logic [3:0] oe_e[4] = '{`SFPI_OE_SINGLE, `SFPI_OE_DUAL, `SFPI_OE_SINGLE, `SFPI_OE_QUAD};
    sfpi_guard_t gt[3] = '{6'h01, 6'h19, 6'h05};
    logic [7:0] lo_e[3] = '{8'h70, 8'h00, 8'h00};
    logic [7:0] hi_e[3] = '{8'h7F, 8'h00, 8'h7F};
    sfpi_pin_front i_dut (
        .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .io_lane_in(lanes),
        .io_lane_out(io_lane_out), .io_lane_oe(io_lane_oe),
        .four_lane_enable_bit(four_lane_enable_bit), .status_lock_bits(status_lock_bits),
        .guard_bits(guard_bits), .phase(phase), .core_busy(core_busy), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_full(rx_full), .rx_overrun(rx_overrun), .selected(selected),
        .paused(paused), .four_lane_command_mode(four_lane_command_mode), .standby(standby),
        .sr_write_refused(sr_write_refused), .protect_any(protect_any),
        .protect_lo(protect_lo), .protect_hi(protect_hi));
    sfpi_host_model i_host (.clk(clk), .dev_out(io_lane_out), .dev_oe(io_lane_oe),
        .sclk(sclk), .cs_n(cs_n), .lanes(lanes));
    always #5 clk = ~clk;
    // overrun is a one-cycle pulse, so keep a sticky copy
    always @(posedge clk) if (rx_overrun === 1'b1) ovr <= 1'b1;
    always @(posedge clk) if (tx_ready === 1'b1) n_txr <= n_txr + 1;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pop(input logic [7:0] e, input logic f);
        int k;
        k = 0;
        while (rx_valid !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        chk("rx_data", e, rx_word.data);
        chk("rx_first", 8'(f), 8'(rx_word.first));
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
        // let the pop settle so the next look sees the new head
        @(posedge clk);
    endtask
    task automatic frame(input logic [7:0] ins);
        i_host.cs(1'b1);
        i_host.cs(1'b0);
        i_host.xfer(ins, 1, 1'b0, 8, rd);
    endtask
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        reset <= 1'b1;
        four_lane_enable_bit <= 1'b0;
        status_lock_bits <= 2'h0;
        guard_bits <= 6'h00;
        phase <= 3'h0;
        core_busy <= 1'b0;
        tx_data <= 8'h3C;
        tx_valid <= 1'b1;
        rx_ready <= 1'b0;
        repeat (20) @(posedge clk);
        chk("oe_in_reset", 8'h00, 8'(io_lane_oe));
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        i_host.xfer(8'h9F, 1, 1'b0, 8, rd);
        repeat (6) @(posedge clk);
        chk("rx_unarmed", 8'h00, 8'(rx_valid));
        i_host.cs(1'b1);
        chk("oe_deselect", 8'h00, 8'(io_lane_oe));
        chk("standby", 8'h01, 8'(standby));
        core_busy <= 1'b1;
        repeat (4) @(posedge clk);
        chk("standby_busy", 8'h00, 8'(standby));
        core_busy <= 1'b0;
        frame(8'h02);
        i_host.xfer(8'h77, 1, 1'b0, 8, rd);
        chk("selected", 8'h01, 8'(selected));
        chk("oe_write", 8'h00, 8'(io_lane_oe));
        pop(8'h02, 1'b1);
        pop(8'h77, 1'b0);
        $display("test select and write done");
        for (int m = 0; m < 4; m++) begin
            four_lane_enable_bit <= (m == 3);
            phase <= {wt[m], 1'b1};
            tx_data <= 8'h3C ^ 8'(m);
            tx_valid <= (m != 1);
            frame(8'hEB);
            txr0 = n_txr;
            i_host.xfer(8'h00, wl[m], 1'b1, 8, rd);
            chk("read_data", (m == 1) ? `SFPI_IDLE_BYTE : 8'h3C ^ 8'(m), rd);
            chk("tx_ready", 8'(m != 1), 8'(n_txr != txr0));
            chk("read_oe", 8'(oe_e[m]), 8'(io_lane_oe));
            pop(8'hEB, 1'b1);
        end
        $display("test read widths done");
        phase <= 3'h0;
        for (int q = 0; q < 2; q++) begin
            four_lane_enable_bit <= q[0];
            frame(`SFPI_CMD_FOUR_LANE_ON);
            i_host.cs(1'b1);
            chk("cmd_mode", 8'(q), 8'(four_lane_command_mode));
            pop(`SFPI_CMD_FOUR_LANE_ON, 1'b1);
        end
        i_host.cs(1'b0);
        i_host.xfer(8'hC3, 4, 1'b0, 8, rd);
        pop(8'hC3, 1'b1);
        i_host.cs(1'b1);
        i_host.cs(1'b0);
        i_host.xfer(`SFPI_CMD_FOUR_LANE_OFF, 4, 1'b0, 8, rd);
        i_host.cs(1'b1);
        chk("cmd_mode_off", 8'h00, 8'(four_lane_command_mode));
        pop(`SFPI_CMD_FOUR_LANE_OFF, 1'b1);
        $display("test four lane command done");
        four_lane_enable_bit <= 1'b0;
        i_host.cs(1'b0);
        i_host.xfer(8'hA0, 1, 1'b0, 4, rd);
        i_host.pin(4'h7);
        chk("paused", 8'h01, 8'(paused));
        i_host.xfer(8'h3C, 1, 1'b0, 8, rd);
        i_host.pin(4'hF);
        i_host.xfer(8'h50, 1, 1'b0, 4, rd);
        pop(8'hA5, 1'b1);
        four_lane_enable_bit <= 1'b1;
        i_host.pin(4'h7);
        chk("paused_qe", 8'h00, 8'(paused));
        status_lock_bits <= `SFPI_LOCK_HARDWARE;
        i_host.pin(4'hB);
        chk("refused_qe", 8'h00, 8'(sr_write_refused));
        four_lane_enable_bit <= 1'b0;
        repeat (4) @(posedge clk);
        chk("refused", 8'h01, 8'(sr_write_refused));
        for (int g = 0; g < 3; g++) begin
            guard_bits <= gt[g];
            repeat (4) @(posedge clk);
            chk("prot_any", 8'h01, 8'(protect_any));
            chk("prot_lo", lo_e[g], 8'(protect_lo));
            chk("prot_hi", hi_e[g], 8'(protect_hi));
        end
        i_host.pin(4'hF);
        $display("test pause and guard done");
        frame(8'h11);
        i_host.xfer(8'h22, 1, 1'b0, 8, rd);
        i_host.xfer(8'h33, 1, 1'b0, 8, rd);
        repeat (6) @(posedge clk);
        chk("rx_full", 8'h01, 8'(rx_full));
        chk("rx_overrun", 8'h01, 8'(ovr));
        pop(8'h11, 1'b1);
        pop(8'h22, 1'b0);
        repeat (2) @(posedge clk);
        chk("rx_drained", 8'h00, 8'(rx_valid));
        $display("test buffer done");
        summarize();
    end
endmodule // sfpi_pin_front_tb
`default_nettype wire

// File: sfpi_pkg.sv
// types of the serial flash pin front end
package sfpi_pkg;
    typedef enum logic [1:0] {sfpi_w1, sfpi_w2, sfpi_w4} sfpi_width_t;
    typedef struct packed {
        sfpi_width_t width;
        logic drive;
    } sfpi_phase_t;
    typedef struct packed {
        logic [7:0] data;
        logic first;
    } sfpi_rx_t;
    typedef struct packed {
        logic cmp;
        logic sec;
        logic tb;
        logic [2:0] bp;
    } sfpi_guard_t;
endpackage
